//--- rtl/pmic_event_debounce.sv
`timescale 1ns/1ns
`include "pmic_evt_params.svh"
// Function
// R1: id pin grounded, open, detect done and bus-voltage done are live sense outputs
// R2: short-circuit flag sets after the condition holds between 4 and 8 ms
// R3: button one falling and held low 30 ms sets a flag
// R4: button one sense follows its level; rising edge flagged after 30 ms
// R5: button two behaves like button one: fall flag, rise flag, level sense
// R6: two-bit select per button lengthens the falling-edge debounce
// R7: button-driven system reset sets a flag with no debounce
// R8: watchdog silent restart sets a flag with no debounce
// R9: timekeeping domain reset sets a flag with no debounce
// R10: clock source change flagged on both edges; sense high while crystal is source
// R11: four temperature flags set on both crossings after programmable debounce, with sense
// R12: each general input flags on programmable edge after programmable debounce, with sense
// R13: interrupt output low except in watchdog and on states
// R14: register writes act only in watchdog, on and user-off-wait states
// R15: flags latch until cleared by writing one; a coinciding event wins
// R16: interrupt high while any flag set with its mask bit clear
// R17: masks reset to all ones; unmasking a set flag raises the line at once
// R18: sense bits are live, never latched or cleared
// R19: rise is low-to-high, fall is high-to-low, dual is either, of debounced source
// R20: tick, alarm, power cut, warm start and memory retain flag on rising source

// ----------------------------------------------------------------
// debounce: output follows input once it has differed for one cycle more than hold_rise_i (rising) or hold_fall_i (falling)
// ----------------------------------------------------------------
module pmic_event_debounce #(
  parameter int CW = 24
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // sample and result
  input  wire logic          in_i,
  input  wire logic [CW-1:0] hold_rise_i,
  input  wire logic [CW-1:0] hold_fall_i,
  output logic               out_o
);
  logic [CW-1:0] cnt_q;
  logic          out_q;
  wire           differs = in_i != out_q;
  wire  [CW-1:0] hold    = in_i ? hold_rise_i : hold_fall_i;
  wire           done    = differs && (cnt_q >= hold);

  // count while input disagrees; restart on any bounce back
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= (differs && !done) ? cnt_q + CW'(1) : '0;
      if (done) begin
        out_q <= in_i;
      end
    end
  end
  assign out_o = out_q;
endmodule

// ----------------------------------------------------------------
// event interrupt logic top
// ----------------------------------------------------------------
module pmic_event_interrupt_logic #(
  parameter int CW        = 24,
  parameter int SC_DB     = `SC_DB_CYC,
  parameter int BTN_DB    = `BTN_DB_CYC,
  parameter int BTN_EXT   = `BTN_DB_CYC,
  parameter int TEMP_UNIT = 125000,
  parameter int NGPI      = 4
) (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // power state
  input  wire pmic_evt_pkg::power_state_e power_state_i,
  // raw event sources (asynchronous)
  input  wire logic                   idpin_grounded_i,
  input  wire logic                   idpin_open_i,
  input  wire logic                   idpin_detect_done_i,
  input  wire logic                   busvolt_detect_done_i,
  input  wire logic                   short_circuit_i,
  input  wire logic                   second_tick_i,
  input  wire logic                   alarm_i,
  input  wire logic                   button_one_i,
  input  wire logic                   button_two_i,
  input  wire logic                   button_reset_i,
  input  wire logic                   watchdog_restart_i,
  input  wire logic                   power_cut_i,
  input  wire logic                   warm_start_i,
  input  wire logic                   memory_retain_i,
  input  wire logic                   clock_source_xtal_i,
  input  wire logic                   timekeeping_reset_i,
  input  wire logic [3:0]             temp_above_i,
  input  wire logic [NGPI-1:0]        general_input_i,
  // configuration
  input  wire logic [1:0]             button_one_debounce_sel_i,
  input  wire logic [1:0]             button_two_debounce_sel_i,
  input  wire logic [1:0]             temperature_debounce_sel_i,
  input  wire logic [2*NGPI-1:0]      general_input_edge_i,
  input  wire logic [2*NGPI-1:0]      general_input_debounce_i,
  // processor writes
  input  wire logic                   clear_wr_i,
  input  wire logic [`NUM_FLAGS-1:0]  clear_data_i,
  input  wire logic                   mask_wr_i,
  input  wire logic [`NUM_FLAGS-1:0]  mask_data_i,
  // status
  output logic [`NUM_FLAGS-1:0]       flags_o,
  output logic [`NUM_FLAGS-1:0]       masks_o,
  output logic                        idpin_grounded_sense_o,
  output logic                        idpin_open_sense_o,
  output logic                        idpin_detect_done_sense_o,
  output logic                        busvolt_detect_done_sense_o,
  output logic                        button_one_sense_o,
  output logic                        button_two_sense_o,
  output logic                        clock_source_sense_o,
  output logic [3:0]                  temp_sense_o,
  output logic [NGPI-1:0]             general_input_sense_o,
  output logic                        int_o
);
  localparam int NRAW = 20 + NGPI;

  // ----------------------------------------------------------------
  // two-flop synchronisers for every raw event source
  // ----------------------------------------------------------------
  wire  [NRAW-1:0] raw = {general_input_i, temp_above_i, timekeeping_reset_i, clock_source_xtal_i,
                          memory_retain_i, warm_start_i, power_cut_i, watchdog_restart_i,
                          button_reset_i, button_two_i, button_one_i, alarm_i, second_tick_i,
                          short_circuit_i, busvolt_detect_done_i, idpin_detect_done_i,
                          idpin_open_i, idpin_grounded_i};
  logic [NRAW-1:0] meta_q;
  logic [NRAW-1:0] sync_q;
  logic [NRAW-1:0] prev_q;

  // sync_q is the only reader of meta_q; prev_q feeds edge detectors
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  wire s_sc   = sync_q[4];
  wire s_b1   = sync_q[7];
  wire s_b2   = sync_q[8];
  wire s_clk  = sync_q[14];

  // ----------------------------------------------------------------
  // debounced sources
  // ----------------------------------------------------------------
  localparam logic [CW-1:0] SC_H  = CW'(SC_DB);
  localparam logic [CW-1:0] BTN_H = CW'(BTN_DB);
  localparam logic [CW-1:0] EXT_H = CW'(BTN_EXT);
  localparam logic [CW-1:0] TU_H  = CW'(TEMP_UNIT);
  // falling debounce grows by one extension step per select code
  wire [CW-1:0] b1_fall_h = BTN_H + CW'(EXT_H * button_one_debounce_sel_i); // R6
  wire [CW-1:0] b2_fall_h = BTN_H + CW'(EXT_H * button_two_debounce_sel_i); // R6
  wire [CW-1:0] temp_h    = CW'(TU_H * ({1'b0, temperature_debounce_sel_i} + 3'h1));
  logic         sc_db;
  logic         b1_db;
  logic         b2_db;
  logic [3:0]   temp_db;
  logic [NGPI-1:0] gpi_db;

  // short circuit only debounced on its rising side; release is immediate
  pmic_event_debounce #(.CW(CW)) u_db_sc (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i(s_sc),
    .hold_rise_i(SC_H), .hold_fall_i('0), .out_o(sc_db)); // R2
  pmic_event_debounce #(.CW(CW)) u_db_b1 (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i(s_b1),
    .hold_rise_i(BTN_H), .hold_fall_i(b1_fall_h), .out_o(b1_db)); // R3 R4
  pmic_event_debounce #(.CW(CW)) u_db_b2 (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i(s_b2),
    .hold_rise_i(BTN_H), .hold_fall_i(b2_fall_h), .out_o(b2_db)); // R5

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_temp
      pmic_event_debounce #(.CW(CW)) u_db_t (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i(sync_q[16+gi]),
        .hold_rise_i(temp_h), .hold_fall_i(temp_h), .out_o(temp_db[gi])); // R11
    end
    for (gi = 0; gi < NGPI; gi++) begin : g_gpi
      wire [CW-1:0] gh = CW'(BTN_H * general_input_debounce_i[2*gi +: 2]);
      pmic_event_debounce #(.CW(CW)) u_db_g (.clk_i(clk_i), .rst_n_i(rst_n_i), .in_i(sync_q[20+gi]),
        .hold_rise_i(gh), .hold_fall_i(gh), .out_o(gpi_db[gi])); // R12
    end
  endgenerate

  // ----------------------------------------------------------------
  // edge detection on debounced and synchronised sources
  // ----------------------------------------------------------------
  logic          sc_db_q;
  logic          b1_db_q;
  logic          b2_db_q;
  logic [3:0]    temp_db_q;
  logic [NGPI-1:0] gpi_db_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sc_db_q   <= 1'b0;
      b1_db_q   <= 1'b0;
      b2_db_q   <= 1'b0;
      temp_db_q <= '0;
      gpi_db_q  <= '0;
    end else begin
      sc_db_q   <= sc_db;
      b1_db_q   <= b1_db;
      b2_db_q   <= b2_db;
      temp_db_q <= temp_db;
      gpi_db_q  <= gpi_db;
    end
  end

  wire [NRAW-1:0] rise = sync_q & ~prev_q; // R19
  wire [NRAW-1:0] fall = ~sync_q & prev_q; // R19
  logic [NGPI-1:0] gpi_evt;

  // programmable edge selection per general input
  always_comb begin
    for (int i = 0; i < NGPI; i++) begin
      unique case (pmic_evt_pkg::edge_sel_e'(general_input_edge_i[2*i +: 2]))
        pmic_evt_pkg::EDGE_NONE: gpi_evt[i] = 1'b0;
        pmic_evt_pkg::EDGE_RISE: gpi_evt[i] = gpi_db[i] & ~gpi_db_q[i];
        pmic_evt_pkg::EDGE_FALL: gpi_evt[i] = ~gpi_db[i] & gpi_db_q[i];
        pmic_evt_pkg::EDGE_DUAL: gpi_evt[i] = gpi_db[i] ^ gpi_db_q[i]; // R12
      endcase
    end
  end

  // one-cycle event per flag position
  wire [`NUM_FLAGS-1:0] evt = {
    gpi_evt,                                    // R12
    temp_db ^ temp_db_q,                        // R11
    rise[15],                                   // R9
    s_clk ^ prev_q[14],                         // R10
    rise[13], rise[12], rise[11],               // R20
    rise[10],                                   // R8
    rise[9],                                    // R7
    b2_db & ~b2_db_q, ~b2_db & b2_db_q,         // R5
    b1_db & ~b1_db_q,                           // R4
    ~b1_db & b1_db_q,                           // R3
    rise[6], rise[5],                           // R20
    sc_db & ~sc_db_q};                          // R2

  // ----------------------------------------------------------------
  // flags, masks and interrupt line
  // ----------------------------------------------------------------
  wire wr_ok = (power_state_i == pmic_evt_pkg::PS_WATCHDOG) || (power_state_i == pmic_evt_pkg::PS_ON) ||
               (power_state_i == pmic_evt_pkg::PS_USER_WAIT); // R14
  wire int_ok = (power_state_i == pmic_evt_pkg::PS_WATCHDOG) || (power_state_i == pmic_evt_pkg::PS_ON);
  wire [`NUM_FLAGS-1:0] clr = (clear_wr_i && wr_ok) ? clear_data_i : '0;
  logic [`NUM_FLAGS-1:0] flag_q;
  logic [`NUM_FLAGS-1:0] mask_q;

  // a new event wins over a clear in the same cycle, so nothing is lost
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_q <= '0;
      mask_q <= `MASK_RESET; // R17
    end else begin
      flag_q <= (flag_q & ~clr) | evt; // R15
      if (mask_wr_i && wr_ok) begin
        mask_q <= mask_data_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions on flags, masks and interrupt line
  // ----------------------------------------------------------------
  // line stays quiet in every state but watchdog and on
  property p_int_quiet;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(power_state_i inside {pmic_evt_pkg::PS_WATCHDOG, pmic_evt_pkg::PS_ON}) |-> !int_o;
  endproperty
  a_int_quiet: assert property (p_int_quiet) else $error("interrupt high in a quiet state"); // R13

  // an unmasked pending flag must raise the line in the on state
  property p_int_pending;
    @(posedge clk_i) disable iff (!rst_n_i)
      (power_state_i == pmic_evt_pkg::PS_ON) && ((flags_o & ~masks_o) != '0) |-> int_o;
  endproperty
  a_int_pending: assert property (p_int_pending) else $error("unmasked flag without interrupt"); // R16

  // fully masked or empty flags keep the line low
  property p_int_masked;
    @(posedge clk_i) disable iff (!rst_n_i)
      ((flags_o & ~masks_o) == '0) |-> !int_o;
  endproperty
  a_int_masked: assert property (p_int_masked) else $error("interrupt with nothing unmasked"); // R16

  // a set flag only drops when it was cleared
  property p_flag_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> (($past(flag_q) & ~$past(clr) & ~flag_q) == '0);
  endproperty
  a_flag_latch: assert property (p_flag_latch) else $error("flag dropped without a clear"); // R15

  // an event always lands, even against a clear of the same bit
  property p_evt_wins;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> (($past(evt) & ~flag_q) == '0);
  endproperty
  a_evt_wins: assert property (p_evt_wins) else $error("event lost"); // R15

  // a clear without a coinciding event empties the bit
  property p_clear_takes;
    @(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> (($past(clr) & ~$past(evt) & flag_q) == '0);
  endproperty
  a_clear_takes: assert property (p_clear_takes) else $error("clear did not take"); // R15

  // masks only change in states that accept writes
  property p_mask_refused;
    @(posedge clk_i) disable iff (!rst_n_i)
      !wr_ok |=> $stable(mask_q);
  endproperty
  a_mask_refused: assert property (p_mask_refused) else $error("mask changed in a closed state"); // R14

  // first cycle out of reset shows every event masked
  property p_mask_reset;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(rst_n_i) |-> (mask_q == `MASK_RESET);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("masks not all set after reset"); // R17

  // combinational so that unmasking a set flag raises the line at once
  assign int_o  = int_ok && |(flag_q & ~mask_q); // R13 R16 R17
  assign flags_o = flag_q;
  assign masks_o = mask_q;

  // live sense bits straight from the synchronisers
  assign idpin_grounded_sense_o      = sync_q[0]; // R1
  assign idpin_open_sense_o          = sync_q[1]; // R1
  assign idpin_detect_done_sense_o   = sync_q[2]; // R1
  assign busvolt_detect_done_sense_o = sync_q[3]; // R1
  assign button_one_sense_o          = s_b1;      // R4 R18
  assign button_two_sense_o          = s_b2;      // R5 R18
  assign clock_source_sense_o        = s_clk;     // R10
  assign temp_sense_o                = sync_q[19:16];   // R11
  assign general_input_sense_o       = sync_q[NRAW-1:20]; // R12
endmodule

//--- pkg/pmic_evt_params.svh
`ifndef PMIC_EVT_PARAMS_SVH
`define PMIC_EVT_PARAMS_SVH
// clock and debounce timing
`define CLK_HZ          125000000
`define SC_DB_MIN_US    4000
`define SC_DB_MAX_US    8000
`define BTN_DB_MS       30
`define SC_DB_CYC       ((`SC_DB_MIN_US * (`CLK_HZ / 1000000) + `SC_DB_MAX_US * (`CLK_HZ / 1000000)) / 2)
`define BTN_DB_CYC      (`BTN_DB_MS * (`CLK_HZ / 1000))
// flag vector bit positions
`define F_SC            0
`define F_TICK          1
`define F_ALARM         2
`define F_B1_FALL       3
`define F_B1_RISE       4
`define F_B2_FALL       5
`define F_B2_RISE       6
`define F_BRST          7
`define F_WDOG          8
`define F_PCUT          9
`define F_WARM          10
`define F_MEMR          11
`define F_CLK           12
`define F_TKRST         13
`define F_TEMP          14
`define F_GPI           18
`define NUM_FLAGS       22
`define MASK_RESET      22'h3FFFFF
`endif

//--- pkg/pmic_evt_pkg.sv
package pmic_evt_pkg;
  // power states seen by the event logic
  typedef enum logic [2:0] {
    PS_OFF      = 3'h0,
    PS_COLD     = 3'h1,
    PS_WATCHDOG = 3'h2,
    PS_ON       = 3'h3,
    PS_USER_WAIT= 3'h4,
    PS_LOWPWR   = 3'h5,
    PS_WARM     = 3'h6,
    PS_COIN     = 3'h7
  } power_state_e;
  // edge selection for programmable events
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_DUAL = 2'h3
  } edge_sel_e;
endpackage

//--- dv/proc_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// processor model: clear and mask writes
// ----------------------------------------------------------------
module proc_model (
  // clock and power state
  input  wire logic                       clk_i,
  input  wire pmic_evt_pkg::power_state_e power_state_i,
  // register writes
  output logic                            clear_wr_o,
  output logic [21:0]                     clear_data_o,
  output logic                            mask_wr_o,
  output logic [21:0]                     mask_data_o
);
  // idle at time zero
  initial begin
    clear_wr_o = 1'b0;
    mask_wr_o = 1'b0;
    clear_data_o = 22'h0;
    mask_data_o = 22'h0;
  end
  // one-cycle strobe; data is scrambled after release so stale values never match
  task automatic wr(input logic is_mask, input logic [21:0] d);
    @(posedge clk_i);
    #1;
    if (is_mask) begin
      mask_wr_o = 1'b1;
      mask_data_o = d;
    end else begin
      clear_wr_o = 1'b1;
      clear_data_o = d;
    end
    @(posedge clk_i);
    #1;
    clear_wr_o = 1'b0;
    mask_wr_o = 1'b0;
    clear_data_o = ~d;
    mask_data_o = ~d;
  endtask
  // writes only count in watchdog, on and user-off-wait; callers check before relying
  function automatic logic live();
    return power_state_i inside {pmic_evt_pkg::PS_WATCHDOG, pmic_evt_pkg::PS_ON, pmic_evt_pkg::PS_USER_WAIT};
  endfunction
endmodule

//--- dv/pmic_event_interrupt_logic_tb_top.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// event interrupt logic bench
// ----------------------------------------------------------------
module pmic_event_interrupt_logic_tb_top;
  localparam int DB = 20;
  localparam int TU = 10;
  localparam int POS [8] = '{1, 2, 7, 8, 9, 10, 11, 13};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pmic_evt_pkg::power_state_e st = pmic_evt_pkg::PS_ON;
  logic sc = 1'b0, xt = 1'b0, cw, mw, irq, xs;
  logic [1:0] btn = 2'h3, bsn, tsel = 2'h0;
  logic [3:0] idp = 4'h0, tmp = 4'h0, gpi = 4'h0, bsel = 4'h0, ids, tps, gps;
  logic [7:0] ev = 8'h00, ge = 8'h00, gdb = 8'h00;
  logic [21:0] flags, masks, cd, md;
  logic [31:0] r;
  int bad_count = 0, check_count = 0, cyc = 0, k;

  proc_model pm (.clk_i(clk), .power_state_i(st), .clear_wr_o(cw), .clear_data_o(cd),
    .mask_wr_o(mw), .mask_data_o(md));
  pmic_event_interrupt_logic #(.SC_DB(DB), .BTN_DB(DB), .BTN_EXT(DB), .TEMP_UNIT(TU)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .power_state_i(st), .idpin_grounded_i(idp[0]), .idpin_open_i(idp[1]),
    .idpin_detect_done_i(idp[2]), .busvolt_detect_done_i(idp[3]), .short_circuit_i(sc),
    .second_tick_i(ev[0]), .alarm_i(ev[1]), .button_one_i(btn[0]), .button_two_i(btn[1]),
    .button_reset_i(ev[2]), .watchdog_restart_i(ev[3]), .power_cut_i(ev[4]), .warm_start_i(ev[5]),
    .memory_retain_i(ev[6]), .clock_source_xtal_i(xt), .timekeeping_reset_i(ev[7]), .temp_above_i(tmp),
    .general_input_i(gpi), .button_one_debounce_sel_i(bsel[1:0]), .button_two_debounce_sel_i(bsel[3:2]),
    .temperature_debounce_sel_i(tsel), .general_input_edge_i(ge), .general_input_debounce_i(gdb),
    .clear_wr_i(cw), .clear_data_i(cd), .mask_wr_i(mw), .mask_data_i(md), .flags_o(flags), .masks_o(masks),
    .idpin_grounded_sense_o(ids[0]), .idpin_open_sense_o(ids[1]), .idpin_detect_done_sense_o(ids[2]),
    .busvolt_detect_done_sense_o(ids[3]), .button_one_sense_o(bsn[0]), .button_two_sense_o(bsn[1]),
    .clock_source_sense_o(xs), .temp_sense_o(tps), .general_input_sense_o(gps), .int_o(irq));

  // clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic clr_all();
    pm.wr(1'b0, 22'h3FFFFF);
    step(1);
  endtask
  // flag bits expected from a set of undebounced pulses
  function automatic logic [21:0] ev_map(input logic [7:0] e);
    ev_map = 22'h0;
    for (int i = 0; i < 8; i++) ev_map[POS[i]] = e[i];
  endfunction
  // rise selects bit 0 of the code, fall bit 1, dual both
  function automatic logic [3:0] gexp(input logic [7:0] e, input int f);
    for (int i = 0; i < 4; i++) gexp[i] = e[2*i+f];
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // main sequence
  initial begin
    r = $urandom(32'hA3E4);
    step(8);
    rst_n = 1'b1;
    step(1);
    chk(masks, 22'h3FFFFF);
    chk(flags, 22'h0);
    chk(irq, 1'b0);
    step(DB + 10);
    clr_all();
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      r = (i == 0) ? 32'hFF : $urandom;
      ev = r[7:0];
      step(1);
      ev = 8'h00;
      step(6);
      chk(flags, ev_map(r[7:0]));
      chk(irq, 1'b0);
      clr_all();
      chk(flags, 22'h0);
    end
    $display("test events done");
    ev = 8'h01;
    step(1);
    ev = 8'h00;
    step(6);
    pm.wr(1'b1, 22'h3FFFFD);
    step(1);
    chk(irq, 1'b1);
    chk(masks, 22'h3FFFFD);
    for (int s = 0; s < 8; s++) begin
      st = pmic_evt_pkg::power_state_e'(s);
      step(1);
      chk(irq, s inside {2, 3});
    end
    st = pmic_evt_pkg::PS_OFF;
    pm.wr(1'b0, 22'h2);
    step(1);
    chk(flags[1], !pm.live());
    pm.wr(1'b1, 22'h0);
    step(1);
    chk(masks, 22'h3FFFFD);
    st = pmic_evt_pkg::PS_USER_WAIT;
    pm.wr(1'b0, 22'h2);
    step(1);
    chk(flags[1], 1'b0);
    st = pmic_evt_pkg::PS_ON;
    $display("test states done");
    sc = 1'b1;
    step(DB - 4);
    chk(flags[0], 1'b0);
    step(14);
    chk(flags[0], 1'b1);
    sc = 1'b0;
    clr_all();
    for (int b = 0; b < 2; b++) begin
      k = (b == 0) ? 3 : $urandom % 4;
      bsel[2*b +: 2] = k[1:0];
      btn[b] = 1'b0;
      step(DB * (k + 1) - 4);
      chk(flags[3+2*b], 1'b0);
      step(14);
      chk(flags[3+2*b], 1'b1);
      chk(bsn[b], 1'b0);
      btn[b] = 1'b1;
      step(DB + 10);
      chk(flags[4+2*b], 1'b1);
      chk(bsn[b], 1'b1);
      clr_all();
    end
    $display("test buttons done");
    xt = 1'b1;
    step(6);
    chk({flags[12], xs}, 2'h3);
    clr_all();
    xt = 1'b0;
    step(6);
    chk({flags[12], xs}, 2'h2);
    clr_all();
    r = $urandom;
    tsel = r[5:4];
    k = TU * (tsel + 1) + 8;
    tmp = r[3:0] | 4'h8;
    step(k);
    chk({flags[17:14], tps}, {2{tmp}});
    clr_all();
    tmp = 4'h0;
    step(k);
    chk({flags[17:14], tps}, {r[3:0] | 4'h8, 4'h0});
    clr_all();
    for (int j = 0; j < 2; j++) begin
      ge = (j == 0) ? 8'hE4 : $urandom;
      gdb = (j == 0) ? 8'h00 : 8'hFF;
      k = DB * 3 * j;
      gpi = 4'hF;
      step(k);
      chk(flags[21:18], 4'h0);
      step(6);
      chk({flags[21:18], gps}, {gexp(ge, 0), 4'hF});
      clr_all();
      gpi = 4'h0;
      step(k);
      chk(flags[21:18], 4'h0);
      step(6);
      chk({flags[21:18], gps}, {gexp(ge, 1), 4'h0});
      clr_all();
    end
    r = $urandom;
    idp = r[3:0];
    step(4);
    clr_all();
    chk(ids, r[3:0]);
    $display("test senses done");
    give_verdict();
  end
endmodule
